//--- rtl/speed_curve_map.svh
// offsets, field positions, reset values and fixed figures of the speed curve block
`ifndef SPEED_CURVE_MAP_SVH
`define SPEED_CURVE_MAP_SVH

`define SC_ADDR_W 4
`define SC_REG_FIRST 4'h2
`define SC_REG_LAST 4'hb
`define SC_REG_STOP 4'h2
`define SC_REG_START 4'h3
`define SC_REG_BRK 4'h4
`define SC_REG_TOP 4'h5
`define SC_REG_SPD_HI 4'h6
`define SC_REG_SPD_LO 4'h7
`define SC_REG_S1_HI 4'h8
`define SC_REG_S1_LO 4'h9
`define SC_REG_S2_HI 4'ha
`define SC_REG_S2_LO 4'hb
`define SC_REG_STATUS 4'hc
`define SC_CFG_RESET 8'h00
`define SC_NO_STOP_BIT 7
`define SC_MAX_OFF_BIT 0
`define SC_OPEN_MAX_BIT 1
`define SC_TOP_OFFSET 10'h101
`define SC_FULL_DUTY 10'h200
`define SC_SLOPE_SHIFT 6

`endif

//--- rtl/speed_curve_pkg.sv
// types shared by the speed curve block
package speed_curve_pkg;
	typedef logic [9:0] duty_t;
	typedef logic [17:0] rpm_t;
	typedef logic [13:0] slope_t;
	typedef logic [7:0] cfg_byte_t;
	typedef struct packed {
		logic open;
		duty_t duty;
		rpm_t rpm;
	} curve_out_t;
	typedef enum logic [4:0] {
		ZONE_ZERO = 5'b00001,
		ZONE_LOW = 5'b00010,
		ZONE_BAND = 5'b00100,
		ZONE_CURVE = 5'b01000,
		ZONE_OPEN = 5'b10000
	} zone_t;
endpackage

//--- rtl/closed_loop_speed_curve.sv
// closed-loop speed curve: speed command duty to target rotation count
// Operation
// - start threshold is register 3, in 1/512 duty steps.
// - stop threshold is register 2 bits 6..0, in 1/256 duty steps.
// - top threshold is register 5 plus 257, in 1/512 steps.
// - start speed is 12 bits: register 6 high, register 7 bits 7..4 low.
// - slope one is 14 bits from registers 8 and 9 bits 7..2.
// - top hysteresis is register 7 bits 3..0, (n+1) times 2/512.
// - open above max passes duty through until duty drops below top minus hysteresis.
// - without no-stop, band between stop and start gives 0 rising, start speed falling.
// - without no-stop, duty up to stop gives 0; zero duty too unless max-off.
// - no-stop without max-off gives start speed at or below start threshold.
// - max-off gives top speed or full duty at zero, up to stop with no-stop.
// - breakpoint duty is register 4 times 2, in 1/512 steps.
// - slope two from registers 10 and 11 applies from breakpoint to top.
// - with breakpoint, slope one ends there; slope scaled by 64 per 1/512 step.
// - breakpoint works together with open-above-max, no-stop and max-off.
`timescale 1ns/100ps
`include "speed_curve_map.svh"

module closed_loop_speed_curve (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic reg_we_i,
	input wire logic [`SC_ADDR_W-1:0] reg_addr_i,
	input wire speed_curve_pkg::cfg_byte_t reg_wdata_i,
	output speed_curve_pkg::cfg_byte_t reg_rdata_o,
	input wire speed_curve_pkg::duty_t speed_command_i,
	output speed_curve_pkg::rpm_t target_rpm_o,
	output logic open_loop_o,
	output speed_curve_pkg::duty_t out_duty_o
);
	import speed_curve_pkg::*;

	cfg_byte_t cfg_r [`SC_REG_LAST:`SC_REG_FIRST];
	cfg_byte_t rdata_r;
	duty_t last_duty_r;
	logic dir_up_r;
	logic hold_open_r;
	curve_out_t out_r;
	curve_out_t out_nxt;

	duty_t start_d;
	duty_t stop_d;
	duty_t top_d;
	duty_t brk_d;
	duty_t hyst_d;
	duty_t clamp_d;
	rpm_t start_speed;
	rpm_t brk_rpm;
	rpm_t top_rpm;
	rpm_t curve_rpm;
	slope_t slope_one;
	slope_t slope_two;
	logic no_stop_a;
	logic max_off_b;
	logic open_above_max;
	logic brk_on;
	logic up_now;
	logic open_nxt;
	zone_t zone;

	// base plus slope times offset over 64, saturated so a bad setting cannot wrap
	function automatic rpm_t seg_rpm(input rpm_t base, input slope_t slope, input duty_t delta);
		logic [23:0] prod;
		logic [18:0] sum;
		prod = {10'h000, slope} * {14'h0000, delta};
		sum = {1'b0, base} + {1'b0, prod[23:`SC_SLOPE_SHIFT]};
		seg_rpm = sum[18] ? 18'h3ffff : sum[17:0];
	endfunction

	// configuration write port; addresses outside the map are ignored
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = `SC_REG_FIRST; i <= `SC_REG_LAST; i++)
				cfg_r[i] <= `SC_CFG_RESET;
		end
		else if (reg_we_i && reg_addr_i >= `SC_REG_FIRST && reg_addr_i <= `SC_REG_LAST)
			cfg_r[reg_addr_i] <= reg_wdata_i;
	end

	// registered read port; status shows direction and open state, unmapped reads zero
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			rdata_r <= 8'h00;
		else if (reg_addr_i >= `SC_REG_FIRST && reg_addr_i <= `SC_REG_LAST)
			rdata_r <= cfg_r[reg_addr_i];
		else if (reg_addr_i == `SC_REG_STATUS)
			rdata_r <= {6'h00, hold_open_r, dir_up_r};
		else
			rdata_r <= 8'h00;
	end

	// field decode, all thresholds brought to 1/512 duty steps
	assign start_d = {2'b00, cfg_r[`SC_REG_START]};
	assign stop_d = {2'b00, cfg_r[`SC_REG_STOP][6:0], 1'b0};
	assign top_d = {2'b00, cfg_r[`SC_REG_TOP]} + `SC_TOP_OFFSET;
	assign start_speed = {6'h00, cfg_r[`SC_REG_SPD_HI], cfg_r[`SC_REG_SPD_LO][7:4]};
	assign slope_one = {cfg_r[`SC_REG_S1_HI], cfg_r[`SC_REG_S1_LO][7:2]};
	assign hyst_d = {5'h00, cfg_r[`SC_REG_SPD_LO][3:0], 1'b0} + 10'h002;
	assign brk_d = {1'b0, cfg_r[`SC_REG_BRK], 1'b0};
	assign slope_two = {cfg_r[`SC_REG_S2_HI], cfg_r[`SC_REG_S2_LO][7:2]};
	assign no_stop_a = cfg_r[`SC_REG_STOP][`SC_NO_STOP_BIT];
	assign max_off_b = cfg_r[`SC_REG_S1_LO][`SC_MAX_OFF_BIT];
	assign open_above_max = cfg_r[`SC_REG_S1_LO][`SC_OPEN_MAX_BIT];
	// a zero breakpoint disables it; the host must keep it inside start..top
	assign brk_on = (brk_d != 10'h000);

	// curve evaluation; command clamped at the top threshold
	assign clamp_d = (speed_command_i > top_d) ? top_d : speed_command_i;
	// the breakpoint speed is shared by the segment-two paths of the curve and of the top speed
	assign brk_rpm = seg_rpm(start_speed, slope_one, brk_d - start_d);
	always_comb
	begin
		if (brk_on && clamp_d > brk_d)
			curve_rpm = seg_rpm(brk_rpm, slope_two, clamp_d - brk_d);
		else
			curve_rpm = seg_rpm(start_speed, slope_one, clamp_d - start_d);
		if (brk_on && top_d > brk_d)
			top_rpm = seg_rpm(brk_rpm, slope_two, top_d - brk_d);
		else
			top_rpm = seg_rpm(start_speed, slope_one, top_d - start_d);
	end

	// direction of the command; an unchanged command keeps the last direction
	assign up_now = (speed_command_i > last_duty_r) ? 1'b1 :
		(speed_command_i < last_duty_r) ? 1'b0 : dir_up_r;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			last_duty_r <= 10'h000;
			dir_up_r <= 1'b1;
		end
		else
		begin
			last_duty_r <= speed_command_i;
			dir_up_r <= up_now;
		end
	end

	// open-above-max with hysteresis so the loop does not chatter at the top
	assign open_nxt = open_above_max && (speed_command_i >= top_d ||
		(hold_open_r && speed_command_i + hyst_d >= top_d));

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			hold_open_r <= 1'b0;
		else
			hold_open_r <= open_nxt;
	end

	// zone of the current command
	// the open zone is tested first so a held open state is not cut by the zero or low zones
	always_comb
	begin
		if (open_nxt)
			zone = ZONE_OPEN;
		else if (speed_command_i == 10'h000)
			zone = ZONE_ZERO;
		else if (speed_command_i <= stop_d)
			zone = ZONE_LOW;
		else if (speed_command_i <= start_d)
			zone = ZONE_BAND;
		else
			zone = ZONE_CURVE;
	end

	// target selection per zone and option bits
	always_comb
	begin
		out_nxt = '{open: 1'b0, duty: 10'h000, rpm: 18'h00000};
		unique case (zone)
			ZONE_OPEN:
			begin
				out_nxt.open = 1'b1;
				out_nxt.duty = speed_command_i;
			end
			ZONE_ZERO:
			begin
				if (max_off_b && open_above_max)
				begin
					out_nxt.open = 1'b1;
					out_nxt.duty = `SC_FULL_DUTY;
				end
				else if (max_off_b)
					out_nxt.rpm = top_rpm;
				else if (no_stop_a)
					out_nxt.rpm = start_speed;
				else
					out_nxt.rpm = 18'h00000;
			end
			ZONE_LOW:
			begin
				if (no_stop_a && max_off_b && open_above_max)
				begin
					out_nxt.open = 1'b1;
					out_nxt.duty = `SC_FULL_DUTY;
				end
				else if (no_stop_a && max_off_b)
					out_nxt.rpm = top_rpm;
				else if (no_stop_a)
					out_nxt.rpm = start_speed;
				else
					out_nxt.rpm = 18'h00000;
			end
			ZONE_BAND:
			begin
				if (no_stop_a || !up_now)
					out_nxt.rpm = start_speed;
				else
					out_nxt.rpm = 18'h00000;
			end
			ZONE_CURVE:
				out_nxt.rpm = curve_rpm;
		endcase
	end

	// output register
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			out_r <= '{open: 1'b0, duty: 10'h000, rpm: 18'h00000};
		else
			out_r <= out_nxt;
	end

	assign reg_rdata_o = rdata_r;
	assign target_rpm_o = out_r.rpm;
	assign open_loop_o = out_r.open;
	assign out_duty_o = out_r.duty;

	a_zero_cmd_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(speed_command_i == 10'h000 && !max_off_b && !no_stop_a) |=> (target_rpm_o == 18'h00000 && !open_loop_o))
		else $error("zero command did not stop");
	a_low_cmd_stop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(speed_command_i != 10'h000 && speed_command_i <= stop_d && !no_stop_a && !open_nxt)
		|=> (target_rpm_o == 18'h00000))
		else $error("command below stop threshold gave nonzero target");
	a_band_rising: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(speed_command_i > stop_d && speed_command_i <= start_d && speed_command_i > last_duty_r && !no_stop_a)
		|=> (target_rpm_o == 18'h00000))
		else $error("rising command in band gave nonzero target");
	a_band_falling: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(speed_command_i > stop_d && speed_command_i <= start_d && speed_command_i < last_duty_r && !open_nxt)
		|=> (target_rpm_o == $past(start_speed)))
		else $error("falling command in band did not give start speed");
	a_no_stop_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(no_stop_a && !max_off_b && speed_command_i <= start_d && !open_nxt)
		|=> (target_rpm_o == $past(start_speed) && !open_loop_o))
		else $error("no-stop did not give start speed");
	a_max_off_full: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(max_off_b && open_above_max && speed_command_i == 10'h000)
		|=> (open_loop_o && out_duty_o == `SC_FULL_DUTY))
		else $error("max-off with open option did not give full duty");
	a_open_pass: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(open_above_max && speed_command_i >= top_d) |=> (open_loop_o && out_duty_o == $past(speed_command_i)))
		else $error("open above max did not pass duty through");
	a_open_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(hold_open_r && speed_command_i != 10'h000 && speed_command_i + hyst_d < top_d
		&& !(no_stop_a && max_off_b && speed_command_i <= stop_d)) |=> !open_loop_o)
		else $error("open mode held below hysteresis point");
	a_curve_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(speed_command_i == start_d + 10'h001 && !open_nxt && (!brk_on || brk_d > start_d))
		|=> (target_rpm_o == $past(start_speed + {10'h000, cfg_r[`SC_REG_S1_HI]})))
		else $error("first curve step wrong");
	a_cfg_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_we_i && reg_addr_i == `SC_REG_START) ##1 (!reg_we_i && reg_addr_i == `SC_REG_START)
		|=> (reg_rdata_o == $past(reg_wdata_i, 2)))
		else $error("start threshold write not read back");
	// two-cycle checks want no write in either cycle, since a write moves the curve at the next edge
	a_clamp_top: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!open_above_max && speed_command_i > top_d && !reg_we_i)
		##1 (!open_above_max && speed_command_i == top_d && !reg_we_i) |=> $stable(target_rpm_o))
		else $error("command above top threshold not clamped");
	a_max_off_top: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!open_above_max && speed_command_i >= top_d && !reg_we_i)
		##1 (max_off_b && !open_above_max && speed_command_i == 10'h000 && !reg_we_i) |=> $stable(target_rpm_o))
		else $error("max-off zero command did not give top speed");
	a_full_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(no_stop_a && max_off_b && open_above_max && speed_command_i != 10'h000 && speed_command_i <= stop_d
		&& !open_nxt) |=> (open_loop_o && out_duty_o == `SC_FULL_DUTY))
		else $error("no-stop with max-off did not give full duty up to stop");
	a_open_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(hold_open_r && open_above_max && speed_command_i + hyst_d >= top_d)
		|=> (open_loop_o && out_duty_o == $past(speed_command_i)))
		else $error("open mode dropped inside hysteresis band");
	a_slope_two_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(brk_on && speed_command_i == brk_d && brk_d + 10'h040 <= top_d && !open_above_max && !reg_we_i)
		##1 (speed_command_i == brk_d + 10'h040 && !open_above_max && !reg_we_i)
		|=> (target_rpm_o == $past(target_rpm_o) + {4'h0, $past(slope_two)}))
		else $error("slope two step over 64 duty steps wrong");
	a_curve_rising: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!open_above_max && speed_command_i > start_d && !reg_we_i)
		##1 (!open_above_max && speed_command_i > $past(speed_command_i) && !reg_we_i)
		|=> (target_rpm_o >= $past(target_rpm_o)))
		else $error("target fell while command rose on the curve");
endmodule

//--- sim/host_model.sv
// host model: register writes and reads, speed command
`timescale 1ns/100ps
module host_model (
	input wire logic sys_clk_i,
	output logic reg_we_o,
	output logic [3:0] reg_addr_o,
	output speed_curve_pkg::cfg_byte_t reg_wdata_o,
	input wire speed_curve_pkg::cfg_byte_t reg_rdata_i,
	output speed_curve_pkg::duty_t speed_command_o
);
	import speed_curve_pkg::*;
	initial
	begin
		reg_we_o = 1'b0;
		reg_addr_o = 4'h0;
		reg_wdata_o = 8'h00;
		speed_command_o = 10'h000;
	end
	// one strobe per write; data inverted once released so stale data never looks valid
	task wr(input logic [3:0] a, input cfg_byte_t d);
		@(negedge sys_clk_i);
		reg_we_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge sys_clk_i);
		reg_we_o = 1'b0;
		reg_wdata_o = ~d;
	endtask
	// read data shows one edge after the address
	task rd(input logic [3:0] a, output cfg_byte_t d);
		@(negedge sys_clk_i);
		reg_addr_o = a;
		@(negedge sys_clk_i);
		d = reg_rdata_i;
	endtask
	// command is held; outputs settle one edge later
	task cmd(input duty_t d);
		@(negedge sys_clk_i);
		speed_command_o = d;
		@(negedge sys_clk_i);
	endtask
endmodule

//--- sim/testbench.sv
// self-checking bench for the closed-loop speed curve
`timescale 1ns/100ps
module testbench;
	import speed_curve_pkg::*;
	logic sys_clk, rst_n, we, opn;
	logic [3:0] addr;
	cfg_byte_t wdata, rdata, rb;
	duty_t cmd, dty;
	rpm_t rpm;
	int errors = 0;
	int checked = 0;
	closed_loop_speed_curve DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .reg_we_i(we), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .speed_command_i(cmd), .target_rpm_o(rpm),
		.open_loop_o(opn), .out_duty_o(dty));
	host_model host (.sys_clk_i(sys_clk), .reg_we_o(we), .reg_addr_o(addr), .reg_wdata_o(wdata),
		.reg_rdata_i(rdata), .speed_command_o(cmd));
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task chk(input string n, input logic [17:0] s, input logic [17:0] e);
		checked++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// write, then read back what the register should now hold
	task wrc(input logic [3:0] a, input cfg_byte_t d, input cfg_byte_t e);
		host.wr(a, d);
		host.rd(a, rb);
		chk("reg", {10'd0, rb}, {10'd0, e});
	endtask
	// rpm is only meaningful while the loop is closed
	task go(input duty_t c, input logic o, input duty_t d, input rpm_t r);
		host.cmd(c);
		chk("open", {17'd0, opn}, {17'd0, o});
		chk("duty", {8'd0, dty}, {8'd0, d});
		if (!o)
			chk("rpm", rpm, r);
	endtask
	task finish_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// watchdog: a hang counts as a mismatch
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		finish_test;
	end
	initial
	begin
		rst_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		chk("rpm", rpm, 18'd0);
		host.rd(4'h3, rb);
		chk("reg", {10'd0, rb}, 18'd0);
		$display("test reset done");
		wrc(4'h3, 8'h66, 8'h66);
		wrc(4'h2, 8'h2e, 8'h2e);
		wrc(4'h5, 8'hcc, 8'hcc);
		wrc(4'h6, 8'h5d, 8'h5d);
		wrc(4'h7, 8'hc9, 8'hc9);
		wrc(4'h8, 8'h25, 8'h25);
		wrc(4'h9, 8'h9c, 8'h9c);
		wrc(4'h1, 8'h55, 8'h00);
		$display("test registers done");
		go(10'd200, 1'b0, 10'd0, 18'd5185);
		go(10'd512, 1'b0, 10'd0, 18'd15001);
		go(10'd461, 1'b0, 10'd0, 18'd15001);
		go(10'd0, 1'b0, 10'd0, 18'd0);
		go(10'd50, 1'b0, 10'd0, 18'd0);
		go(10'd100, 1'b0, 10'd0, 18'd0);
		go(10'd200, 1'b0, 10'd0, 18'd5185);
		go(10'd100, 1'b0, 10'd0, 18'd1500);
		go(10'd103, 1'b0, 10'd0, 18'd1537);
		$display("test curve done");
		host.wr(4'h9, 8'h9d);
		go(10'd512, 1'b0, 10'd0, 18'd15001);
		go(10'd0, 1'b0, 10'd0, 18'd15001);
		go(10'd50, 1'b0, 10'd0, 18'd0);
		host.wr(4'h2, 8'hae);
		go(10'd50, 1'b0, 10'd0, 18'd15001);
		go(10'd100, 1'b0, 10'd0, 18'd1500);
		host.wr(4'h9, 8'h9c);
		go(10'd0, 1'b0, 10'd0, 18'd1500);
		go(10'd50, 1'b0, 10'd0, 18'd1500);
		host.wr(4'h2, 8'h2e);
		$display("test low zone done");
		host.wr(4'h9, 8'h9e);
		go(10'd470, 1'b1, 10'd470, 18'd0);
		go(10'd445, 1'b1, 10'd445, 18'd0);
		host.rd(4'hc, rb);
		chk("status", {10'd0, rb}, 18'h00002);
		go(10'd440, 1'b0, 10'd0, 18'd14211);
		host.wr(4'h9, 8'h9f);
		go(10'd0, 1'b1, 10'h200, 18'd0);
		host.wr(4'h2, 8'hae);
		go(10'd50, 1'b1, 10'h200, 18'd0);
		$display("test open loop done");
		// breakpoint kept between start and top thresholds
		wrc(4'h2, 8'h2e, 8'h2e);
		wrc(4'h4, 8'h80, 8'h80);
		wrc(4'ha, 8'h30, 8'h30);
		wrc(4'hb, 8'hc8, 8'hc8);
		go(10'd300, 1'b0, 10'd0, 18'd9437);
		go(10'd470, 1'b1, 10'd470, 18'd0);
		host.wr(4'h9, 8'h9c);
		go(10'd300, 1'b0, 10'd0, 18'd9437);
		go(10'd200, 1'b0, 10'd0, 18'd5185);
		go(10'd256, 1'b0, 10'd0, 18'd7291);
		go(10'd320, 1'b0, 10'd0, 18'd10413);
		$display("test breakpoint done");
		finish_test;
	end
endmodule
